// [pkg/cc_defines.svh]
// Constants for the condition code logic: fields, codes and addresses.
//
// How it works
// - Only general ALU, transfer or wide-format microops load microflags, at cycle end.
// - Microflag N takes result bit 7, 15 or 31 by size.
// - Zero is cumulative: byte 7..0, word adds 15..8, long adds 31..16.
// - Microflag V is the size's sign-bit overflow indicator.
// - Microflag C takes carry out of bit 7, 15 or 31 by size.
// - Opcode flag class is captured at class decode and held.
// - Class 00 copies N, Z, V, C straight into status flags.
// - Classes 01 and 10 load inverted C; class 01 copies N, Z, V.
// - Class 11 holds status C and copies N and Z.
// - Class 10 loads status N with N xor V, Z directly.
// - Classes 11 and 10 clear status V on a copy.
// - Load select 00 byte, 01 word, 10 longword, 11 hold.
// - Flag field 00 holds microflags and status flags.
// - Flag field 01 captures longword indicators, no copy.
// - Flag field 10 captures indicators by operand size code, no copy.
// - Legacy mode with longword size makes field 10 capture word indicators.
// - Flag field 11 copies into status flags and holds microflags.
// - Other microops hold both flag sets.
// - All microflags and status C are skip conditions.
// - Transfer at address FE reads microflags onto D bus 3..0.
// - Transfer at address FD or FE writes microflags from Y bus 3..0.
// - ALU or transfer at 7F or FF reads or writes status flags.
// - Flag field sits in control store bits 6..5 and sets operand size.
// - Size code 00 byte, 01 word, 11 longword, 10 unused.
`ifndef CC_DEFINES_SVH
`define CC_DEFINES_SVH

// --------------------------------------------------------------------
// Microinstruction field and flag positions
// --------------------------------------------------------------------
`define CC_FIELD_HI 6
`define CC_FIELD_LO 5
`define FLAG_N 3
`define FLAG_Z 2
`define FLAG_V 1
`define FLAG_C 0
`define FLAGS_RESET 4'h0

// --------------------------------------------------------------------
// Codes
// --------------------------------------------------------------------
`define FIELD_NOP 2'h0
`define FIELD_LONG 2'h1
`define FIELD_SIZE 2'h2
`define FIELD_COPY 2'h3
`define SEL_BYTE 2'h0
`define SEL_WORD 2'h1
`define SEL_LONG 2'h2
`define SEL_HOLD 2'h3
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h3
`define CLASS_ADD 2'h0
`define CLASS_SUB 2'h1
`define CLASS_CMP 2'h2
`define CLASS_LOGIC 2'h3

// --------------------------------------------------------------------
// Discrete register addresses
// --------------------------------------------------------------------
`define ADDR_MICRO_WR 8'hfd
`define ADDR_MICRO_RW 8'hfe
`define ADDR_STATUS_LO 8'h7f
`define ADDR_STATUS_HI 8'hff

`endif

// [pkg/cc_pkg.sv]
// Types shared by the condition code logic.
package cc_pkg;
  typedef enum logic [2:0] {
    OP_GENERAL_ALU,
    OP_TRANSFER,
    OP_WIDE_FORMAT,
    OP_MEM_REQ,
    OP_DECODE,
    OP_JUMP,
    OP_MISC,
    OP_PORT
  } microop_t;
  typedef logic [3:0] flags_t;
  typedef logic [1:0] code_t;
endpackage

// [pkg/cc_sel_if.sv]
// Carrier between the flag control and the indicator selector.
`timescale 1ns/1ps
interface cc_sel_if;
  cc_pkg::code_t loadSelect;
  logic [31:0] aluResult;
  logic [2:0] carryOut;
  logic [2:0] overflow;
  cc_pkg::flags_t picked;
  modport sel (
    input loadSelect, aluResult, carryOut, overflow,
    output picked
  );
  modport ctl (
    output loadSelect, aluResult, carryOut, overflow,
    input picked
  );
endinterface

// [verilog/cc_indicator_select.sv]
// Picks the result indicators for the size named by the load select.
`timescale 1ns/1ps
`include "cc_defines.svh"
module cc_indicator_select (
  cc_sel_if.sel bus
);
  logic [2:0] sign;
  logic [2:0] zeroSlice;
  logic [2:0] zeroCum;

  // -------------------------------------------------------------------
  // Per-size indicators
  // -------------------------------------------------------------------
  // Slice i covers bits Lo..Hi; zero ANDs slice i with the slices below it.
  for (genvar i = 0; i < 3; i++) begin : g_size
    localparam int Hi = (8 << i) - 1;
    localparam int Lo = (i == 0) ? 0 : (4 << i);
    assign sign[i] = bus.aluResult[Hi];
    assign zeroSlice[i] = ~|bus.aluResult[Hi:Lo];
    assign zeroCum[i] = &zeroSlice[i:0];
  end

  // -------------------------------------------------------------------
  // Size choice
  // -------------------------------------------------------------------
  // Hold gives zeros; the caller does not load on hold anyway.
  always_comb begin
    bus.picked = `FLAGS_RESET;
    unique case (bus.loadSelect)
      `SEL_BYTE: bus.picked = {sign[0], zeroCum[0],
        bus.overflow[0], bus.carryOut[0]};
      `SEL_WORD: bus.picked = {sign[1], zeroCum[1],
        bus.overflow[1], bus.carryOut[1]};
      `SEL_LONG: bus.picked = {sign[2], zeroCum[2],
        bus.overflow[2], bus.carryOut[2]};
      `SEL_HOLD: bus.picked = `FLAGS_RESET;
    endcase
  end
endmodule

// [verilog/condition_code_logic.sv]
// Microflags, status flags and their load and copy control.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "cc_defines.svh"
module condition_code_logic #(
  parameter int CswWidth = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire cc_pkg::microop_t microOp,
  input wire logic [CswWidth-1:0] controlStoreWord,
  input wire cc_pkg::code_t sizeCode,
  input wire logic legacyModeFlag,
  input wire logic classDecode,
  input wire cc_pkg::code_t opcodeClassIn,
  input wire logic [31:0] aluResult,
  input wire logic [2:0] carryOut,
  input wire logic [2:0] overflow,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [3:0] writeData,
  output logic [3:0] readData,
  output cc_pkg::flags_t statusFlags,
  output cc_pkg::code_t opcodeFlagClass,
  output logic skipMicroN,
  output logic skipMicroZ,
  output logic skipMicroV,
  output logic skipMicroC,
  output logic skipStatusC
);

  // -------------------------------------------------------------------
  // Decode helpers
  // -------------------------------------------------------------------
  // Operand size set by the flag field; legacy mode never goes long.
  function automatic cc_pkg::code_t dataTypeOf(
    input cc_pkg::code_t field,
    input cc_pkg::code_t size,
    input logic legacy
  );
    cc_pkg::code_t dt;
    dt = (field == `FIELD_NOP || field == `FIELD_LONG) ?
      `SIZE_LONG : size;
    if (legacy && dt == `SIZE_LONG) begin
      dt = `SIZE_WORD;
    end
    return dt;
  endfunction

  // Size code to load select; the unused code 10 holds the flags.
  function automatic cc_pkg::code_t selectOf(input cc_pkg::code_t dt);
    cc_pkg::code_t s;
    unique case (dt)
      `SIZE_BYTE: s = `SEL_BYTE;
      `SIZE_WORD: s = `SEL_WORD;
      `SIZE_LONG: s = `SEL_LONG;
      default: s = `SEL_HOLD;
    endcase
    return s;
  endfunction

  // New status flags from microflags for one opcode flag class.
  function automatic cc_pkg::flags_t copyOf(
    input cc_pkg::flags_t m,
    input cc_pkg::flags_t s,
    input cc_pkg::code_t cls
  );
    cc_pkg::flags_t r;
    r = m;
    unique case (cls)
      `CLASS_ADD: r = m;
      `CLASS_SUB: r[`FLAG_C] = ~m[`FLAG_C];
      `CLASS_CMP: begin
        r[`FLAG_N] = m[`FLAG_N] ^ m[`FLAG_V];
        r[`FLAG_V] = 1'b0;
        r[`FLAG_C] = ~m[`FLAG_C];
      end
      `CLASS_LOGIC: begin
        r[`FLAG_V] = 1'b0;
        r[`FLAG_C] = s[`FLAG_C];
      end
    endcase
    return r;
  endfunction

  // -------------------------------------------------------------------
  // Control decode
  // -------------------------------------------------------------------
  cc_pkg::flags_t microflags;
  cc_pkg::code_t ccField;
  cc_pkg::code_t dataType;
  cc_pkg::code_t loadSelect;
  logic isAluOp;
  logic microflagLoadSelectHi;
  logic microflagLoadSelectLo;
  logic statusFlagCopyEnable;
  logic microflagWriteStrobe;
  logic statusFlagWriteStrobe;
  logic microAddr;
  logic statusAddr;

  assign ccField = controlStoreWord[`CC_FIELD_HI:`CC_FIELD_LO];
  assign dataType = dataTypeOf(ccField, sizeCode, legacyModeFlag);
  assign isAluOp = microOp == cc_pkg::OP_GENERAL_ALU ||
    microOp == cc_pkg::OP_TRANSFER ||
    microOp == cc_pkg::OP_WIDE_FORMAT;

  // Memory, decode, jump, misc and port ops leave both sets alone.
  always_comb begin
    loadSelect = `SEL_HOLD;
    statusFlagCopyEnable = 1'b0;
    if (isAluOp) begin
      unique case (ccField)
        `FIELD_NOP: loadSelect = `SEL_HOLD;
        `FIELD_LONG: loadSelect = `SEL_LONG;
        `FIELD_SIZE: loadSelect = selectOf(dataType);
        `FIELD_COPY: begin
          loadSelect = `SEL_HOLD;
          statusFlagCopyEnable = 1'b1;
        end
      endcase
    end
  end

  assign microflagLoadSelectHi = loadSelect[1];
  assign microflagLoadSelectLo = loadSelect[0];

  // Discrete register address decode.
  assign microAddr = regAddr == `ADDR_MICRO_RW;
  assign statusAddr = regAddr == `ADDR_STATUS_LO ||
    regAddr == `ADDR_STATUS_HI;
  assign microflagWriteStrobe = regWrite &&
    microOp == cc_pkg::OP_TRANSFER &&
    (microAddr || regAddr == `ADDR_MICRO_WR);
  assign statusFlagWriteStrobe = regWrite && statusAddr &&
    (microOp == cc_pkg::OP_GENERAL_ALU ||
     microOp == cc_pkg::OP_TRANSFER);

  // -------------------------------------------------------------------
  // Indicator selection
  // -------------------------------------------------------------------
  cc_sel_if selBus ();

  assign selBus.loadSelect = {microflagLoadSelectHi,
    microflagLoadSelectLo};
  assign selBus.aluResult = aluResult;
  assign selBus.carryOut = carryOut;
  assign selBus.overflow = overflow;

  cc_indicator_select indicators (
    .bus(selBus.sel)
  );

  // -------------------------------------------------------------------
  // Flag registers
  // -------------------------------------------------------------------
  // A write from the Y bus wins over a load in the same microcycle,
  // so microcode forcing a value is never undone by its own field.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      microflags <= `FLAGS_RESET;
    end else if (microflagWriteStrobe) begin
      microflags <= writeData;
    end else if (loadSelect != `SEL_HOLD) begin
      microflags <= selBus.picked;
    end
  end

  // Status flags: Y bus write first, then the class-driven copy.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      statusFlags <= `FLAGS_RESET;
    end else if (statusFlagWriteStrobe) begin
      statusFlags <= writeData;
    end else if (statusFlagCopyEnable) begin
      statusFlags <= copyOf(microflags, statusFlags,
        opcodeFlagClass);
    end
  end

  // Class held from decode until the next instruction's decode.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opcodeFlagClass <= `CLASS_ADD;
    end else if (classDecode) begin
      opcodeFlagClass <= opcodeClassIn;
    end
  end

  // -------------------------------------------------------------------
  // Register read port
  // -------------------------------------------------------------------
  // Read data stand for one cycle only; unmapped reads give zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readData <= 4'h0;
    end else if (regRead && microAddr &&
                 microOp == cc_pkg::OP_TRANSFER) begin
      readData <= microflags;
    end else if (regRead && statusAddr &&
                 (microOp == cc_pkg::OP_GENERAL_ALU ||
                  microOp == cc_pkg::OP_TRANSFER)) begin
      readData <= statusFlags;
    end else begin
      readData <= 4'h0;
    end
  end

  // Skip conditions come straight off the flag flip-flops.
  assign skipMicroN = microflags[`FLAG_N];
  assign skipMicroZ = microflags[`FLAG_Z];
  assign skipMicroV = microflags[`FLAG_V];
  assign skipMicroC = microflags[`FLAG_C];
  assign skipStatusC = statusFlags[`FLAG_C];

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic quiet;
  assign quiet = !microflagWriteStrobe && !statusFlagWriteStrobe;

  sequence fieldOp(cc_pkg::code_t f);
    isAluOp && ccField == f && quiet;
  endsequence

  sequence copyOp(cc_pkg::code_t c);
    fieldOp(`FIELD_COPY) ##0 opcodeFlagClass == c;
  endsequence

  other_hold_a: assert property (
    !isAluOp && quiet |=> $stable(microflags) && $stable(statusFlags))
    else $error("Flags changed on a non-ALU microop.");

  nop_hold_a: assert property (
    fieldOp(`FIELD_NOP) |=> $stable(microflags) && $stable(statusFlags))
    else $error("Nop flag field changed flags.");

  long_sign_a: assert property (
    fieldOp(`FIELD_LONG) |=>
      microflags[`FLAG_N] == $past(aluResult[31]) &&
      $stable(statusFlags))
    else $error("Longword sign not loaded.");

  long_zero_a: assert property (
    fieldOp(`FIELD_LONG) |=>
      microflags[`FLAG_Z] == ($past(aluResult) == 32'h0))
    else $error("Longword zero wrong.");

  word_overflow_a: assert property (
    fieldOp(`FIELD_SIZE) ##0 sizeCode == `SIZE_WORD |=>
      microflags[`FLAG_V] == $past(overflow[1]))
    else $error("Word overflow not loaded.");

  byte_carry_a: assert property (
    fieldOp(`FIELD_SIZE) ##0 sizeCode == `SIZE_BYTE |=>
      microflags[`FLAG_C] == $past(carryOut[0]))
    else $error("Byte carry not loaded.");

  legacy_word_a: assert property (
    fieldOp(`FIELD_SIZE) ##0 sizeCode == `SIZE_LONG &&
    legacyModeFlag |=>
      microflags[`FLAG_N] == $past(aluResult[15]) &&
      microflags[`FLAG_C] == $past(carryOut[1]))
    else $error("Legacy longword did not load word indicators.");

  copy_add_a: assert property (
    copyOp(`CLASS_ADD) |=>
      statusFlags == $past(microflags) && $stable(microflags))
    else $error("Add class copy wrong.");

  copy_sub_a: assert property (
    copyOp(`CLASS_SUB) |=>
      statusFlags == ($past(microflags) ^ 4'h1))
    else $error("Subtract class copy wrong.");

  copy_cmp_a: assert property (
    copyOp(`CLASS_CMP) |=>
      statusFlags[`FLAG_N] ==
        ($past(microflags[`FLAG_N]) ^ $past(microflags[`FLAG_V])) &&
      !statusFlags[`FLAG_V] &&
      statusFlags[`FLAG_C] == !$past(microflags[`FLAG_C]))
    else $error("Compare class copy wrong.");

  copy_logic_a: assert property (
    copyOp(`CLASS_LOGIC) |=>
      $stable(statusFlags[`FLAG_C]) && !statusFlags[`FLAG_V] &&
      statusFlags[3:2] == $past(microflags[3:2]))
    else $error("Logical class copy wrong.");

  class_hold_a: assert property (
    !classDecode |=> $stable(opcodeFlagClass))
    else $error("Opcode flag class changed without decode.");

  micro_write_a: assert property (
    microflagWriteStrobe |=> microflags == $past(writeData))
    else $error("Microflag write lost.");

  micro_read_a: assert property (
    regRead && microAddr && microOp == cc_pkg::OP_TRANSFER |=>
      readData == $past(microflags) ##1
      (readData == 4'h0 || $past(regRead)))
    else $error("Microflag read wrong.");

  status_write_a: assert property (
    statusFlagWriteStrobe |=> statusFlags == $past(writeData))
    else $error("Status flag write lost.");

  // The remaining sizes, the unused size code and the status read-back.
  // Each slice is checked on its own so a wrong pick cannot hide.
  long_flags_a: assert property (
    fieldOp(`FIELD_LONG) |=>
      microflags[`FLAG_V] == $past(overflow[2]) &&
      microflags[`FLAG_C] == $past(carryOut[2]))
    else $error("Longword overflow or carry not loaded.");

  byte_flags_a: assert property (
    fieldOp(`FIELD_SIZE) ##0 sizeCode == `SIZE_BYTE |=>
      microflags[`FLAG_N] == $past(aluResult[7]) &&
      microflags[`FLAG_Z] == ($past(aluResult[7:0]) == 8'h00))
    else $error("Byte sign or zero not loaded.");

  word_zero_a: assert property (
    fieldOp(`FIELD_SIZE) ##0 sizeCode == `SIZE_WORD |=>
      microflags[`FLAG_N] == $past(aluResult[15]) &&
      microflags[`FLAG_Z] == ($past(aluResult[15:0]) == 16'h0000))
    else $error("Word sign or zero not loaded.");

  size_long_a: assert property (
    fieldOp(`FIELD_SIZE) ##0 sizeCode == `SIZE_LONG && !legacyModeFlag |=>
      microflags[`FLAG_N] == $past(aluResult[31]) &&
      microflags[`FLAG_C] == $past(carryOut[2]))
    else $error("Size register longword not loaded.");

  unused_size_a: assert property (
    fieldOp(`FIELD_SIZE) ##0 sizeCode == 2'h2 |=> $stable(microflags))
    else $error("Unused size code changed microflags.");

  copy_hold_a: assert property (
    fieldOp(`FIELD_COPY) |=> $stable(microflags))
    else $error("Copy changed microflags.");

  status_read_a: assert property (
    regRead && statusAddr &&
    (microOp == cc_pkg::OP_GENERAL_ALU || microOp == cc_pkg::OP_TRANSFER)
    |=> readData == $past(statusFlags))
    else $error("Status flag read wrong.");

endmodule

// [sim/alu_model.sv]
// Behavioural adder standing in for the bit-slice ALU data path.
`timescale 1ns/1ps
module alu_model (
  input wire logic [31:0] opA,
  input wire logic [31:0] opB,
  output logic [31:0] result,
  output logic [2:0] carry,
  output logic [2:0] ovf
);
  logic [32:0] full;
  logic [16:0] half;
  logic [8:0] quarter;

  // --------------------------------------------------------------------
  // Indicators
  // --------------------------------------------------------------------
  // Each slice reports its own carry and sign overflow, so a wrong size
  // pick in the block shows up as a wrong flag.
  always_comb begin
    full = {1'b0, opA} + {1'b0, opB};
    half = {1'b0, opA[15:0]} + {1'b0, opB[15:0]};
    quarter = {1'b0, opA[7:0]} + {1'b0, opB[7:0]};
    result = full[31:0];
    carry = {full[32], half[16], quarter[8]};
    ovf[0] = (opA[7] == opB[7]) && (full[7] != opA[7]);
    ovf[1] = (opA[15] == opB[15]) && (full[15] != opA[15]);
    ovf[2] = (opA[31] == opB[31]) && (full[31] != opA[31]);
  end
endmodule

// [sim/testbench.sv]
// Self-checking bench for the condition code logic.
`timescale 1ns/1ps
module testbench;
  localparam cc_pkg::microop_t ALU = cc_pkg::OP_GENERAL_ALU;
  localparam cc_pkg::microop_t XFR = cc_pkg::OP_TRANSFER;
  localparam cc_pkg::microop_t WID = cc_pkg::OP_WIDE_FORMAT;
  localparam cc_pkg::microop_t MEM = cc_pkg::OP_MEM_REQ;
  localparam cc_pkg::microop_t IDL = cc_pkg::OP_MISC;
  typedef struct {
    cc_pkg::code_t fld;
    cc_pkg::code_t sz;
    logic leg;
    cc_pkg::microop_t op;
    logic [31:0] a;
    logic [31:0] b;
    cc_pkg::flags_t em;
    cc_pkg::flags_t es;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cc_pkg::microop_t microOp = IDL;
  logic [15:0] controlStoreWord = 16'h0000;
  cc_pkg::code_t sizeCode = 2'h0;
  logic legacyModeFlag = 1'b0;
  logic classDecode = 1'b0;
  cc_pkg::code_t opcodeClassIn = 2'h0;
  logic [31:0] opA = 32'h0;
  logic [31:0] opB = 32'h0;
  logic [7:0] regAddr = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [3:0] writeData = 4'h0;
  logic [31:0] aluResult;
  logic [2:0] carryOut;
  logic [2:0] overflow;
  logic [3:0] readData;
  cc_pkg::flags_t statusFlags;
  cc_pkg::code_t opcodeFlagClass;
  logic skipMicroN, skipMicroZ, skipMicroV, skipMicroC, skipStatusC;
  logic [3:0] micro;
  logic [3:0] got;
  int err_count = 0;
  int check_count = 0;
  // Ordinary cases: field, size, legacy, microop, operands, flags out.
  row_t rows [10] = '{
    '{2'h1, 2'h0, 1'b0, ALU, 32'h0, 32'h0, 4'h4, 4'h0},
    '{2'h2, 2'h0, 1'b0, ALU, 32'h7f, 32'h1, 4'ha, 4'h0},
    '{2'h2, 2'h1, 1'b0, ALU, 32'hffff, 32'h1, 4'h5, 4'h0},
    '{2'h2, 2'h3, 1'b0, XFR, 32'h80000000, 32'h80000000, 4'h7, 4'h0},
    '{2'h2, 2'h3, 1'b1, ALU, 32'h7fff, 32'h1, 4'ha, 4'h0},
    '{2'h0, 2'h3, 1'b0, ALU, 32'h0, 32'h0, 4'ha, 4'h0},
    '{2'h1, 2'h3, 1'b0, MEM, 32'h0, 32'h0, 4'ha, 4'h0},
    '{2'h1, 2'h0, 1'b0, WID, 32'hffffffff, 32'h1, 4'h5, 4'h0},
    '{2'h2, 2'h2, 1'b0, ALU, 32'h0, 32'h0, 4'h5, 4'h0},
    '{2'h3, 2'h0, 1'b0, ALU, 32'h0, 32'h0, 4'h5, 4'h5}
  };
  logic [3:0] clsExp [4] = '{4'ha, 4'hb, 4'h1, 4'h9};

  assign micro = {skipMicroN, skipMicroZ, skipMicroV, skipMicroC};

  // Half period of 4 ns gives the 125 MHz clock.
  always #4 clk = ~clk;

  alu_model partner (
    .opA(opA), .opB(opB), .result(aluResult), .carry(carryOut),
    .ovf(overflow)
  );

  condition_code_logic #(.CswWidth(16)) DUT (
    .clk(clk), .rst_n(rst_n), .microOp(microOp),
    .controlStoreWord(controlStoreWord), .sizeCode(sizeCode),
    .legacyModeFlag(legacyModeFlag), .classDecode(classDecode),
    .opcodeClassIn(opcodeClassIn), .aluResult(aluResult),
    .carryOut(carryOut), .overflow(overflow), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .writeData(writeData),
    .readData(readData), .statusFlags(statusFlags),
    .opcodeFlagClass(opcodeFlagClass), .skipMicroN(skipMicroN),
    .skipMicroZ(skipMicroZ), .skipMicroV(skipMicroV),
    .skipMicroC(skipMicroC), .skipStatusC(skipStatusC)
  );

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  // One compare for every four-bit result; case inequality lets no
  // unknown pass.
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Applies one microinstruction for one cycle, then idles.
  task automatic app(input row_t r);
    @(posedge clk);
    microOp <= r.op;
    controlStoreWord <= {9'h155, r.fld, 5'h15};
    sizeCode <= r.sz;
    legacyModeFlag <= r.leg;
    opA <= r.a;
    opB <= r.b;
    @(posedge clk);
    microOp <= IDL;
    #1;
  endtask

  task automatic wr(input cc_pkg::microop_t op, input logic [7:0] ad,
                    input logic [3:0] d);
    @(posedge clk);
    microOp <= op;
    controlStoreWord <= 16'h0000;
    regAddr <= ad;
    writeData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    microOp <= IDL;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input cc_pkg::microop_t op, input logic [7:0] ad,
                    output logic [3:0] d);
    @(posedge clk);
    microOp <= op;
    controlStoreWord <= 16'h0000;
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    microOp <= IDL;
    #1;
    d = readData;
  endtask

  task automatic summarize();
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(micro, 4'h0);
    chk(statusFlags, 4'h0);
    foreach (rows[i]) begin
      app(rows[i]);
      chk(micro, rows[i].em);
      chk(statusFlags, rows[i].es);
    end
    // Every class is copied from the same microflags and status preset.
    for (int c = 0; c < 4; c++) begin
      wr(XFR, 8'hfe, 4'ha);
      wr(ALU, 8'h7f, 4'h7);
      @(posedge clk);
      classDecode <= 1'b1;
      opcodeClassIn <= 2'(c);
      @(posedge clk);
      classDecode <= 1'b0;
      #1;
      chk({2'h0, opcodeFlagClass}, 4'(c));
      app(rows[9]);
      chk(statusFlags, clsExp[c]);
      chk({3'h0, skipStatusC}, {3'h0, clsExp[c][0]});
      chk(micro, 4'ha);
    end
    // Discrete register access and the refused combinations.
    rd(XFR, 8'hfe, got);
    chk(got, 4'ha);
    @(posedge clk);
    #1;
    chk(readData, 4'h0);
    rd(ALU, 8'hfe, got);
    chk(got, 4'h0);
    rd(XFR, 8'hfd, got);
    chk(got, 4'h0);
    wr(XFR, 8'hfd, 4'h3);
    chk(micro, 4'h3);
    wr(ALU, 8'hfe, 4'hc);
    chk(micro, 4'h3);
    wr(XFR, 8'hff, 4'h6);
    rd(ALU, 8'hff, got);
    chk(got, 4'h6);
    wr(MEM, 8'h7f, 4'h1);
    rd(XFR, 8'h7f, got);
    chk(got, 4'h6);
    // A second reset in mid-run clears everything without a clock.
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    chk(micro, 4'h0);
    chk(statusFlags, 4'h0);
    chk({2'h0, opcodeFlagClass}, 4'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    app(rows[1]);
    chk(micro, 4'ha);
    summarize();
  end

  // The whole sequence needs well under 300 cycles.
  initial begin
    #20000;
    err_count++;
    summarize();
  end
endmodule
